// ===== tcc_regs.svh
// register offsets, field positions and reset values of the timer
// assumes a byte-addressed 32-bit register bus, one register per word
`ifndef TCC_REGS_SVH
`define TCC_REGS_SVH

`define TCC_OFS_CTRL 8'h00
`define TCC_OFS_COUNT 8'h04
`define TCC_OFS_WRAP_HI 8'h08
`define TCC_OFS_WRAP_LO 8'h0C
`define TCC_OFS_CH_CFG 8'h10
`define TCC_OFS_CH_HI 8'h14
`define TCC_OFS_CH_LO 8'h18
`define TCC_CH_STRIDE 8'h10
`define TCC_OFS_STATUS 8'h30
`define TCC_OFS_MASK 8'h34

// control register fields
`define TCC_CTRL_PS_HI 2
`define TCC_CTRL_PS_LO 0
`define TCC_CTRL_CLR_BIT 4
`define TCC_CTRL_HALT_BIT 5
`define TCC_PS_EXT 3'h7
`define TCC_PS_RESET 3'h0
`define TCC_HALT_RESET 1'h1
`define TCC_WRAP_RESET 8'hFF

// channel configuration fields
`define TCC_CFG_MAX 0
`define TCC_CFG_TOV 1
`define TCC_CFG_ELS_LO 2
`define TCC_CFG_ELS_HI 3
`define TCC_CFG_MSA 4
`define TCC_CFG_MSB 5
`define TCC_CFG_W 6
`define TCC_CFG_RESET 6'h00

// status and mask fields
`define TCC_STAT_OVF 0
`define TCC_STAT_CH0 1
`define TCC_STAT_W 3
`define TCC_STAT_RESET 3'h0

`endif

// ===== tcc_pkg.sv
// types shared by the timer and its channel slices
// assumes nothing beyond a SystemVerilog compiler
package tcc_pkg;

  typedef enum logic [1:0] {
    TCC_MODE_PRESET = 2'b00,
    TCC_MODE_CAPTURE = 2'b01,
    TCC_MODE_COMPARE = 2'b10,
    TCC_MODE_BUFFERED = 2'b11
  } tcc_mode_type;

  typedef enum logic [1:0] {
    TCC_ACT_NONE = 2'b00,
    TCC_ACT_TOGGLE = 2'b01,
    TCC_ACT_CLEAR = 2'b10,
    TCC_ACT_SET = 2'b11
  } tcc_action_type;

endpackage

// ===== tcc_channel.sv
// one timer channel: pin synchroniser, edge detect, compare and output
// assumes the counter and its pulses come from the same clock domain
`timescale 1ns/10ps
`default_nettype none

module tcc_channel (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic pin_i,
  input wire tcc_pkg::tcc_mode_type mode_i,
  input wire logic [1:0] els_i,
  input wire logic preset_low_i,
  input wire logic tov_i,
  input wire logic max_i,
  input wire logic [15:0] count_i,
  input wire logic count_adv_i,
  input wire logic ovf_i,
  input wire logic [15:0] cmp_val_i,
  input wire logic cmp_hold_i,
  output logic capture_o,
  output logic match_o,
  output logic pin_o,
  output logic pin_oe_o
);

  logic s1_reg, s2_reg, prev_reg, out_reg, out_next, oe_reg, oe_next;
  logic rise, fall;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  ////////////////////////////////////////////////////////////////////////
  always_comb begin
    rise = s2_reg & ~prev_reg;
    fall = ~s2_reg & prev_reg;
    capture_o = (mode_i == tcc_pkg::TCC_MODE_CAPTURE) &&
      ((els_i[0] && rise) || (els_i[1] && fall)); // R5
    match_o = (mode_i == tcc_pkg::TCC_MODE_COMPARE ||
      mode_i == tcc_pkg::TCC_MODE_BUFFERED) && count_adv_i &&
      !cmp_hold_i && count_i == cmp_val_i;
    out_next = out_reg;
    oe_next = 1'h0;
    unique case (mode_i)
      tcc_pkg::TCC_MODE_PRESET: begin
        out_next = ~preset_low_i;
      end
      tcc_pkg::TCC_MODE_CAPTURE: begin
        out_next = out_reg;
      end
      tcc_pkg::TCC_MODE_COMPARE, tcc_pkg::TCC_MODE_BUFFERED: begin
        oe_next = 1'h1;
        // overflow wins over a compare in the same cycle
        if (tov_i && ovf_i) begin
          out_next = ~out_reg; // R10
        end else if (match_o) begin
          unique case (tcc_pkg::tcc_action_type'(els_i)) // R6
            tcc_pkg::TCC_ACT_TOGGLE: out_next = ~out_reg;
            tcc_pkg::TCC_ACT_CLEAR: out_next = 1'h0;
            tcc_pkg::TCC_ACT_SET: out_next = 1'h1;
            tcc_pkg::TCC_ACT_NONE: out_next = out_reg;
          endcase
        end
        if (max_i && !tov_i) begin
          out_next = 1'h1; // R7
        end
      end
    endcase
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      s1_reg <= 1'h0;
      s2_reg <= 1'h0;
      prev_reg <= 1'h0;
      out_reg <= 1'h1;
      oe_reg <= 1'h0;
    end else begin
      s1_reg <= pin_i;
      s2_reg <= s1_reg;
      prev_reg <= s2_reg;
      out_reg <= out_next;
      oe_reg <= oe_next;
    end
  end

  assign pin_o = out_reg;
  assign pin_oe_o = oe_reg;

  ////////////////////////////////////////////////////////////////////////
  sequence seq_ovf_toggle;
    (mode_i == tcc_pkg::TCC_MODE_COMPARE) && tov_i && ovf_i;
  endsequence

  AST_TOV_TOGGLE: assert property (seq_ovf_toggle |=> // R10
    pin_o != $past(pin_o))
    else $error("channel pin did not toggle on overflow");

  AST_SET_ON_MATCH: assert property (match_o && els_i == 2'h3 && // R6
    !(tov_i && ovf_i) |=> pin_o)
    else $error("channel pin not set on compare match");

  AST_CLEAR_ON_MATCH: assert property (match_o && els_i == 2'h2 && // R6
    !(tov_i && ovf_i) && !max_i |=> !pin_o)
    else $error("channel pin not cleared on compare match");

endmodule

`default_nettype wire

// ===== tcc_timer.sv
// two-channel capture/compare timer with an Avalon-MM register slave
// assumes channel pins and the external clock pin are asynchronous
`timescale 1ns/10ps
`default_nettype none
`include "tcc_regs.svh"

// Functional notes
// R1 - a 16-bit up-counter, free-running or modulo, times every channel
// R2 - the wrap limit comes from writable high and low byte registers
// R3 - software reads the counter at any time without disturbing it
// R4 - two channels, each independently capture or compare
// R5 - capture triggers on rising, falling or either edge
// R6 - a compare match sets, clears or toggles the channel output
// R7 - unbuffered and buffered pulse-width modulated outputs
// R8 - counter clock: seven divided bus rates or the external pin
// R9 - the external clock source stays at or below four megahertz
// R10 - per channel, the output may toggle on counter overflow
// R11 - software bits halt the counter and reset it
// R12 - an active capture edge copies the counter into the channel value
// R13 - captured value is the count before the edge plus two
// R14 - capture may raise an interrupt; otherwise software polls a flag
// R15 - in modulo mode the counter returns to zero and flags overflow
module tcc_timer (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [7:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  input wire logic external_timer_clock_pin_i,
  input wire logic [1:0] chan_pin_i,
  output logic [1:0] chan_pin_o,
  output logic [1:0] chan_pin_oe_o,
  output logic irq_o
);

  // bus and register group
  logic wait_reg, wait_next;
  logic [31:0] rdata_reg, rdata_next;
  logic [2:0] ps_reg, ps_next;
  logic halt_reg, halt_next;
  logic [7:0] wrap_hi_reg, wrap_hi_next, wrap_lo_reg, wrap_lo_next;
  logic [`TCC_CFG_W-1:0] cfg_reg [0:1];
  logic [`TCC_CFG_W-1:0] cfg_next [0:1];
  logic [15:0] val_reg [0:1];
  logic [15:0] val_next [0:1];
  logic [1:0] hold_reg, hold_next;
  logic last_wr_reg, last_wr_next, buf_sel_reg, buf_sel_next;
  logic [`TCC_STAT_W-1:0] status_reg, status_next, mask_reg, mask_next;
  logic [`TCC_STAT_W-1:0] stat_clr;
  logic irq_reg, irq_next;

  // counter group
  logic [15:0] cnt_reg, cnt_next;
  logic [5:0] presc_reg, presc_next, rate_mask;
  logic ext_s1_reg, ext_s2_reg, ext_prev_reg;
  logic cnt_adv_reg, cnt_adv_next, ovf_reg, ovf_next;

  logic rd_acc, wr_acc, cnt_clr, tick;
  logic [15:0] wrap_val;
  tcc_pkg::tcc_mode_type mode [0:1];
  logic [15:0] cmp_val [0:1];
  logic [1:0] cmp_hold, ch_capture, ch_match, pin_out, pin_oe;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  ////////////////////////////////////////////////////////////////////////
  // request accepted at the edge where waitrequest is seen low
  always_comb begin
    rd_acc = avs_read_i & ~wait_reg;
    wr_acc = avs_write_i & ~wait_reg & avs_byteenable_i[0];
    cnt_clr = wr_acc && avs_address_i == `TCC_OFS_CTRL &&
      avs_writedata_i[`TCC_CTRL_CLR_BIT]; // R11
    wrap_val = {wrap_hi_reg, wrap_lo_reg}; // R2
  end

  ////////////////////////////////////////////////////////////////////////
  // channel modes; buffered channel 0 takes over channel 1's value
  always_comb begin
    for (int i = 0; i < 2; i++) begin // R4
      if (cfg_reg[i][`TCC_CFG_ELS_HI:`TCC_CFG_ELS_LO] == 2'h0) begin
        mode[i] = tcc_pkg::TCC_MODE_PRESET;
      end else if (cfg_reg[i][`TCC_CFG_MSB]) begin
        mode[i] = tcc_pkg::TCC_MODE_BUFFERED;
      end else if (cfg_reg[i][`TCC_CFG_MSA]) begin
        mode[i] = tcc_pkg::TCC_MODE_COMPARE;
      end else begin
        mode[i] = tcc_pkg::TCC_MODE_CAPTURE;
      end
    end
    if (cfg_reg[0][`TCC_CFG_MSB]) begin
      mode[1] = tcc_pkg::TCC_MODE_PRESET;
    end
    cmp_val[1] = val_reg[1];
    cmp_hold[1] = hold_reg[1];
    if (cfg_reg[0][`TCC_CFG_MSB]) begin
      cmp_val[0] = val_reg[buf_sel_reg]; // R7
      cmp_hold[0] = hold_reg[buf_sel_reg];
    end else begin
      cmp_val[0] = val_reg[0];
      cmp_hold[0] = hold_reg[0];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // prescaler and counter
  always_comb begin
    rate_mask = 6'((7'h01 << ps_reg) - 7'h01);
    if (ps_reg == `TCC_PS_EXT) begin
      // slow pin clock leaves room for the synchroniser and edge detect
      tick = ext_s2_reg & ~ext_prev_reg; // R8 R9
    end else begin
      tick = (presc_reg & rate_mask) == rate_mask; // R8
    end
    presc_next = presc_reg + 6'h01;
    cnt_next = cnt_reg;
    cnt_adv_next = 1'h0;
    ovf_next = 1'h0;
    if (cnt_clr) begin
      presc_next = 6'h00; // R11
      cnt_next = 16'h0000;
    end else if (tick && !halt_reg) begin // R11
      cnt_adv_next = 1'h1;
      // limit below the count: runs on to the natural 16-bit wrap
      if (cnt_reg == wrap_val) begin
        cnt_next = 16'h0000; // R15
        ovf_next = 1'h1;
      end else begin
        cnt_next = cnt_reg + 16'h0001; // R1
      end
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      ext_s1_reg <= 1'h0;
      ext_s2_reg <= 1'h0;
      ext_prev_reg <= 1'h0;
      presc_reg <= 6'h00;
      cnt_reg <= 16'h0000;
      cnt_adv_reg <= 1'h0;
      ovf_reg <= 1'h0;
    end else begin
      ext_s1_reg <= external_timer_clock_pin_i;
      ext_s2_reg <= ext_s1_reg;
      ext_prev_reg <= ext_s2_reg;
      presc_reg <= presc_next;
      cnt_reg <= cnt_next;
      cnt_adv_reg <= cnt_adv_next;
      ovf_reg <= ovf_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // register file, flags and interrupt
  always_comb begin
    wait_next = ~((avs_read_i | avs_write_i) & wait_reg);
    rdata_next = rdata_reg;
    ps_next = ps_reg;
    halt_next = halt_reg;
    wrap_hi_next = wrap_hi_reg;
    wrap_lo_next = wrap_lo_reg;
    cfg_next = cfg_reg;
    val_next = val_reg;
    hold_next = hold_reg;
    last_wr_next = last_wr_reg;
    buf_sel_next = buf_sel_reg;
    mask_next = mask_reg;
    stat_clr = `TCC_STAT_RESET;
    // read data is fixed one edge early and stands through the accept
    if (avs_read_i && wait_reg) begin
      case (avs_address_i)
        `TCC_OFS_CTRL: rdata_next = 32'({halt_reg, 2'h0, ps_reg});
        `TCC_OFS_COUNT: rdata_next = 32'(cnt_reg); // R3
        `TCC_OFS_WRAP_HI: rdata_next = 32'(wrap_hi_reg);
        `TCC_OFS_WRAP_LO: rdata_next = 32'(wrap_lo_reg);
        `TCC_OFS_STATUS: rdata_next = 32'(status_reg); // R14
        `TCC_OFS_MASK: rdata_next = 32'(mask_reg);
        default: rdata_next = 32'h0000_0000;
      endcase
      for (int i = 0; i < 2; i++) begin
        if (avs_address_i == `TCC_OFS_CH_CFG +
            (i[0] ? `TCC_CH_STRIDE : 8'h00)) begin
          rdata_next = 32'(cfg_reg[i]);
        end
        if (avs_address_i == `TCC_OFS_CH_HI +
            (i[0] ? `TCC_CH_STRIDE : 8'h00)) begin
          rdata_next = 32'(val_reg[i][15:8]);
        end
        if (avs_address_i == `TCC_OFS_CH_LO +
            (i[0] ? `TCC_CH_STRIDE : 8'h00)) begin
          rdata_next = 32'(val_reg[i][7:0]);
        end
      end
    end
    if (wr_acc) begin
      case (avs_address_i)
        `TCC_OFS_CTRL: begin
          ps_next = avs_writedata_i[`TCC_CTRL_PS_HI:`TCC_CTRL_PS_LO];
          halt_next = avs_writedata_i[`TCC_CTRL_HALT_BIT]; // R11
        end
        `TCC_OFS_WRAP_HI: wrap_hi_next = avs_writedata_i[7:0]; // R2
        `TCC_OFS_WRAP_LO: wrap_lo_next = avs_writedata_i[7:0]; // R2
        `TCC_OFS_STATUS: stat_clr = avs_writedata_i[`TCC_STAT_W-1:0];
        `TCC_OFS_MASK: mask_next = avs_writedata_i[`TCC_STAT_W-1:0];
        default: mask_next = mask_reg;
      endcase
      for (int i = 0; i < 2; i++) begin
        if (avs_address_i == `TCC_OFS_CH_CFG +
            (i[0] ? `TCC_CH_STRIDE : 8'h00)) begin
          cfg_next[i] = avs_writedata_i[`TCC_CFG_W-1:0];
          if (i[0]) begin
            cfg_next[i][`TCC_CFG_MSB] = 1'h0;
          end
        end
        // high byte write holds compares until the low byte lands
        if (avs_address_i == `TCC_OFS_CH_HI +
            (i[0] ? `TCC_CH_STRIDE : 8'h00)) begin
          val_next[i][15:8] = avs_writedata_i[7:0];
          if (mode[i] != tcc_pkg::TCC_MODE_CAPTURE) begin
            hold_next[i] = 1'h1;
          end
        end
        if (avs_address_i == `TCC_OFS_CH_LO +
            (i[0] ? `TCC_CH_STRIDE : 8'h00)) begin
          val_next[i][7:0] = avs_writedata_i[7:0];
          hold_next[i] = 1'h0;
          last_wr_next = i[0];
        end
      end
    end
    // high byte read freezes captures so the pair reads coherently
    if (rd_acc) begin
      for (int i = 0; i < 2; i++) begin
        if (mode[i] == tcc_pkg::TCC_MODE_CAPTURE) begin
          if (avs_address_i == `TCC_OFS_CH_HI +
              (i[0] ? `TCC_CH_STRIDE : 8'h00)) begin
            hold_next[i] = 1'h1;
          end
          if (avs_address_i == `TCC_OFS_CH_LO +
              (i[0] ? `TCC_CH_STRIDE : 8'h00)) begin
            hold_next[i] = 1'h0;
          end
        end
      end
    end
    for (int i = 0; i < 2; i++) begin
      // sync plus edge detect give the two-count lag
      if (ch_capture[i] && !hold_reg[i]) begin
        val_next[i] = cnt_reg; // R12 R13
      end
    end
    if (ovf_reg) begin
      buf_sel_next = last_wr_reg; // R7
    end
    // a new event wins over a clear in the same cycle
    status_next = (status_reg & ~stat_clr) |
      {ch_capture | ch_match, ovf_reg}; // R14 R15
    irq_next = |(status_next & mask_next); // R14
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      wait_reg <= 1'h1;
      rdata_reg <= 32'h0000_0000;
      ps_reg <= `TCC_PS_RESET;
      halt_reg <= `TCC_HALT_RESET;
      wrap_hi_reg <= `TCC_WRAP_RESET;
      wrap_lo_reg <= `TCC_WRAP_RESET;
      for (int i = 0; i < 2; i++) begin
        cfg_reg[i] <= `TCC_CFG_RESET;
        val_reg[i] <= 16'h0000;
      end
      hold_reg <= 2'h0;
      last_wr_reg <= 1'h0;
      buf_sel_reg <= 1'h0;
      status_reg <= `TCC_STAT_RESET;
      mask_reg <= `TCC_STAT_RESET;
      irq_reg <= 1'h0;
    end else begin
      wait_reg <= wait_next;
      rdata_reg <= rdata_next;
      ps_reg <= ps_next;
      halt_reg <= halt_next;
      wrap_hi_reg <= wrap_hi_next;
      wrap_lo_reg <= wrap_lo_next;
      cfg_reg <= cfg_next;
      val_reg <= val_next;
      hold_reg <= hold_next;
      last_wr_reg <= last_wr_next;
      buf_sel_reg <= buf_sel_next;
      status_reg <= status_next;
      mask_reg <= mask_next;
      irq_reg <= irq_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  for (genvar g = 0; g < 2; g++) begin : gen_chan
    tcc_channel u_chan (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .pin_i(chan_pin_i[g]),
      .mode_i(mode[g]),
      .els_i(cfg_reg[g][`TCC_CFG_ELS_HI:`TCC_CFG_ELS_LO]),
      .preset_low_i(cfg_reg[g][`TCC_CFG_MSA]),
      .tov_i(cfg_reg[g][`TCC_CFG_TOV]),
      .max_i(cfg_reg[g][`TCC_CFG_MAX]),
      .count_i(cnt_reg),
      .count_adv_i(cnt_adv_reg),
      .ovf_i(ovf_reg),
      .cmp_val_i(cmp_val[g]),
      .cmp_hold_i(cmp_hold[g]),
      .capture_o(ch_capture[g]),
      .match_o(ch_match[g]),
      .pin_o(pin_out[g]),
      .pin_oe_o(pin_oe[g])
    );
  end

  assign avs_readdata_o = rdata_reg;
  assign avs_waitrequest_o = wait_reg;
  assign chan_pin_o = pin_out;
  assign chan_pin_oe_o = pin_oe;
  assign irq_o = irq_reg;

  ////////////////////////////////////////////////////////////////////////
  sequence seq_count_read;
    avs_read_i && wait_reg && avs_address_i == `TCC_OFS_COUNT;
  endsequence

  sequence seq_capture0;
    ch_capture[0] && !hold_reg[0];
  endsequence

  AST_COUNT_STEP: assert property (cnt_adv_reg && !ovf_reg |-> // R1
    cnt_reg == $past(cnt_reg) + 16'h0001)
    else $error("counter did not step by one");

  AST_WRAP_ZERO: assert property (ovf_reg |-> cnt_reg == 16'h0000 && // R15
    $past(cnt_reg) == $past(wrap_val))
    else $error("overflow without wrap at limit");

  AST_HALT_HOLDS: assert property (halt_reg && !cnt_clr |=> // R11
    $stable(cnt_reg))
    else $error("counter moved while halted");

  AST_CLEAR_ZERO: assert property (cnt_clr |=> cnt_reg == 16'h0000 && // R11
    presc_reg == 6'h00)
    else $error("counter reset bit ignored");

  AST_COUNT_READ: assert property (seq_count_read |=> // R3
    avs_readdata_o[15:0] == $past(cnt_reg) && !avs_waitrequest_o)
    else $error("count read returned wrong value");

  AST_RATE_HALF: assert property (cnt_adv_reg && ps_reg == 3'h1 && // R8
    $past(ps_reg) == 3'h1 |=> !cnt_adv_reg)
    else $error("divide-by-two rate ticked twice in a row");

  AST_CAPTURE_COPY: assert property (seq_capture0 |=> // R12
    val_reg[0] == $past(cnt_reg))
    else $error("capture did not latch the counter");

  AST_CAPTURE_FLAG: assert property (ch_capture[1] |=> // R14
    status_reg[`TCC_STAT_CH0 + 1])
    else $error("capture flag not set");

  AST_IRQ_LEVEL: assert property (irq_o == // R14
    |(status_reg & mask_reg))
    else $error("interrupt level disagrees with flags");

endmodule

`default_nettype wire

// ===== tcc_pin_model.sv
// far-side pin model: capture edges on channel pins, external count clock
// assumes the bench calls its tasks from one process at a time
`timescale 1ns/10ps
`default_nettype none

module tcc_pin_model (
  input wire logic clk_i,
  output logic ext_clk_o,
  output logic [1:0] pin_o
);
  initial begin
    ext_clk_o = 1'b0;
    pin_o = 2'b00;
  end

  //////////////////////////////////////////////////////////////////////////
  task automatic set_pin(input int idx, input logic val);
    @(posedge clk_i);
    pin_o[idx] <= val;
  endtask

  // clock idles low between bursts; 26-cycle period stays under 4 MHz
  task automatic ext_pulses(input int n);
    repeat (n) begin
      @(posedge clk_i);
      ext_clk_o <= 1'b1;
      repeat (13) @(posedge clk_i);
      ext_clk_o <= 1'b0;
      repeat (12) @(posedge clk_i);
    end
  endtask
endmodule

`default_nettype wire

// ===== tcc_timer_test.sv
// self-checking bench for the two-channel timer
// assumes the pin model stands on the channel and external clock pins
`timescale 1ns/10ps
`default_nettype none
`include "tcc_regs.svh"

module tcc_timer_test;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic [7:0] adr = 8'h00;
  logic rd = 1'b0;
  logic wr = 1'b0;
  logic [31:0] wd = 32'h0000_0000;
  logic [3:0] be = 4'hF;
  logic [31:0] rdat;
  logic wreq;
  logic ext_clk;
  logic [1:0] pin_in;
  logic [1:0] pin_out;
  logic [1:0] pin_oe;
  logic irq;
  logic [31:0] q;
  logic [31:0] a;
  logic [15:0] v;
  int n_fail = 0;
  int num_checks = 0;

  tcc_timer dut (.clk_i(clk_i), .rst_i(rst_i), .avs_address_i(adr),
    .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wd),
    .avs_byteenable_i(be), .avs_readdata_o(rdat),
    .avs_waitrequest_o(wreq), .external_timer_clock_pin_i(ext_clk),
    .chan_pin_i(pin_in), .chan_pin_o(pin_out), .chan_pin_oe_o(pin_oe),
    .irq_o(irq));
  tcc_pin_model pins (.clk_i(clk_i), .ext_clk_o(ext_clk), .pin_o(pin_in));

  initial begin
    forever #5 clk_i = ~clk_i;
  end

  //////////////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      n_fail++;
      $display("FAIL %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic chk_rng(input string nm, input logic [31:0] lo,
                         input logic [31:0] hi, input logic [31:0] g);
    num_checks++;
    if ($isunknown(g) || !(g >= lo && g <= hi)) begin
      n_fail++;
      $display("FAIL %s expected %h..%h seen %h", nm, lo, hi, g);
    end
  endtask

  // request held until waitrequest is sampled low, then released
  task automatic bus(input logic w, input logic [7:0] ad,
                     input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    adr <= ad;
    wd <= d;
    rd <= !w;
    wr <= w;
    do begin
      @(posedge clk_i);
      n++;
    end while (wreq !== 1'b0 && n < 50);
    q = rdat;
    rd <= 1'b0;
    wr <= 1'b0;
    if (n >= 50) chk("bus answer", 32'h0000_0000, 32'h0000_0001);
  endtask

  task automatic wrr(input logic [7:0] ad, input logic [31:0] d);
    bus(1'b1, ad, d);
  endtask

  task automatic rdr(input logic [7:0] ad);
    bus(1'b0, ad, 32'h0000_0000);
  endtask

  task automatic rdc(input string nm, input logic [7:0] ad,
                     input logic [31:0] e);
    rdr(ad);
    chk(nm, e, q);
  endtask

  // high byte first, low byte completes the pair
  task automatic rd16(input int ch);
    rdr(8'(`TCC_OFS_CH_HI + ch * `TCC_CH_STRIDE));
    v[15:8] = q[7:0];
    rdr(8'(`TCC_OFS_CH_LO + ch * `TCC_CH_STRIDE));
    v[7:0] = q[7:0];
  endtask

  // sel 0 watches the interrupt, sel 1 the channel 0 pin
  task automatic wait_lvl(input string nm, input int sel, input logic e);
    int n;
    n = 0;
    while (((sel == 0) ? irq : pin_out[0]) !== e && n < 200) begin
      @(posedge clk_i);
      n++;
    end
    chk(nm, 32'(e), 32'((sel == 0) ? irq : pin_out[0]));
  endtask

  //////////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    chk("pin level", 32'h0000_0003, 32'(pin_out));
    chk("pin enable", 32'h0000_0000, 32'(pin_oe));
    chk("irq", 32'h0000_0000, 32'(irq));
    rdc("ctrl", `TCC_OFS_CTRL, 32'h0000_0020);
    rdc("wrap hi", `TCC_OFS_WRAP_HI, 32'h0000_00FF);
    rdc("wrap lo", `TCC_OFS_WRAP_LO, 32'h0000_00FF);
    rdc("count", `TCC_OFS_COUNT, 32'h0000_0000);
    rdc("status", `TCC_OFS_STATUS, 32'h0000_0000);
    rdc("unmapped", 8'h3C, 32'h0000_0000);
    be <= 4'h0;
    wrr(`TCC_OFS_WRAP_LO, 32'h0000_0012);
    be <= 4'hF;
    rdc("refused write", `TCC_OFS_WRAP_LO, 32'h0000_00FF);
  endtask

  task automatic t_count();
    for (int ps = 0; ps < 7; ps++) begin
      wrr(`TCC_OFS_CTRL, 32'h0000_0030);
      wrr(`TCC_OFS_CTRL, 32'(ps));
      repeat (256) @(posedge clk_i);
      wrr(`TCC_OFS_CTRL, 32'h0000_0020 | 32'(ps));
      rdr(`TCC_OFS_COUNT);
      chk_rng("prescaled", 32'(256 >> ps), 32'((264 >> ps) + 1), q);
    end
    wrr(`TCC_OFS_CTRL, 32'h0000_0000);
    rdr(`TCC_OFS_COUNT);
    a = q;
    rdr(`TCC_OFS_COUNT);
    chk_rng("count step", a + 2, a + 4, q);
    wrr(`TCC_OFS_CTRL, 32'h0000_0030);
    rdc("cleared count", `TCC_OFS_COUNT, 32'h0000_0000);
    rdc("clear bit", `TCC_OFS_CTRL, 32'h0000_0020);
  endtask

  task automatic t_ovf();
    wrr(`TCC_OFS_WRAP_HI, 32'h0000_0000);
    wrr(`TCC_OFS_WRAP_LO, 32'h0000_003F);
    wrr(`TCC_OFS_MASK, 32'h0000_0001);
    wrr(`TCC_OFS_CTRL, 32'h0000_0000);
    wait_lvl("overflow irq", 0, 1'b1);
    wrr(`TCC_OFS_CTRL, 32'h0000_0020);
    rdr(`TCC_OFS_COUNT);
    chk_rng("wrapped", 32'h0000_0000, 32'h0000_003F, q);
    rdc("overflow flag", `TCC_OFS_STATUS, 32'h0000_0001);
    wrr(`TCC_OFS_STATUS, 32'h0000_0001);
    rdc("flag cleared", `TCC_OFS_STATUS, 32'h0000_0000);
    chk("irq cleared", 32'h0000_0000, 32'(irq));
    wrr(`TCC_OFS_MASK, 32'h0000_0000);
    wrr(`TCC_OFS_CTRL, 32'h0000_0000);
    repeat (100) @(posedge clk_i);
    wrr(`TCC_OFS_CTRL, 32'h0000_0020);
    chk("masked irq", 32'h0000_0000, 32'(irq));
    rdc("masked flag", `TCC_OFS_STATUS, 32'h0000_0001);
    wrr(`TCC_OFS_STATUS, 32'h0000_0001);
  endtask

  task automatic t_cmp();
    // preset low first, so the set action has a level to change
    wrr(`TCC_OFS_CH_CFG, 32'h0000_0010);
    wrr(`TCC_OFS_CH_HI, 32'h0000_0000);
    wrr(`TCC_OFS_CH_LO, 32'h0000_0020);
    wrr(`TCC_OFS_CH_CFG, 32'h0000_001C);
    wrr(`TCC_OFS_CTRL, 32'h0000_0030);
    wrr(`TCC_OFS_CTRL, 32'h0000_0000);
    wait_lvl("set on match", 1, 1'b1);
    chk("drive enable", 32'h0000_0001, 32'(pin_oe[0]));
    wrr(`TCC_OFS_CH_CFG, 32'h0000_0018);
    wait_lvl("clear on match", 1, 1'b0);
    wrr(`TCC_OFS_CH_CFG, 32'h0000_0014);
    wait_lvl("toggle up", 1, 1'b1);
    wait_lvl("toggle down", 1, 1'b0);
    wrr(`TCC_OFS_CH_CFG, 32'h0000_001A);
    wait_lvl("overflow toggle", 1, 1'b1);
    wait_lvl("pwm clear", 1, 1'b0);
    wrr(`TCC_OFS_CH_CFG, 32'h0000_0019);
    wait_lvl("full duty", 1, 1'b1);
    repeat (70) @(posedge clk_i);
    chk("full duty held", 32'h0000_0001, 32'(pin_out[0]));
    // buffered: channel 1 value was written last, so it is used
    wrr(`TCC_OFS_CH_HI + `TCC_CH_STRIDE, 32'h0000_0000);
    wrr(`TCC_OFS_CH_LO + `TCC_CH_STRIDE, 32'h0000_0010);
    wrr(`TCC_OFS_CH_CFG, 32'h0000_003A);
    wait_lvl("buffered low", 1, 1'b0);
    wait_lvl("buffered high", 1, 1'b1);
    a = 32'h0000_0000;
    while (pin_out[0] === 1'b1 && a < 32'h0000_0064) begin
      @(posedge clk_i);
      a++;
    end
    chk_rng("buffered duty", 32'h0000_000F, 32'h0000_0011, a);
    wrr(`TCC_OFS_CTRL, 32'h0000_0020);
  endtask

  task automatic t_cap();
    wrr(`TCC_OFS_WRAP_HI, 32'h0000_00FF);
    wrr(`TCC_OFS_WRAP_LO, 32'h0000_00FF);
    wrr(`TCC_OFS_CH_CFG, 32'h0000_0004);
    wrr(`TCC_OFS_CH_CFG + `TCC_CH_STRIDE, 32'h0000_000C);
    wrr(`TCC_OFS_MASK, 32'h0000_0006);
    wrr(`TCC_OFS_STATUS, 32'h0000_0007);
    wrr(`TCC_OFS_CTRL, 32'h0000_0000);
    repeat (40) @(posedge clk_i);
    wrr(`TCC_OFS_CTRL, 32'h0000_0020);
    rdr(`TCC_OFS_COUNT);
    a = q;
    pins.set_pin(0, 1'b1);
    pins.set_pin(1, 1'b1);
    repeat (8) @(posedge clk_i);
    chk("capture irq", 32'h0000_0001, 32'(irq));
    rdc("rising flags", `TCC_OFS_STATUS, 32'h0000_0006);
    rd16(0);
    chk("ch0 capture", a, 32'(v));
    rd16(1);
    chk("ch1 capture", a, 32'(v));
    wrr(`TCC_OFS_STATUS, 32'h0000_0006);
    pins.set_pin(0, 1'b0);
    pins.set_pin(1, 1'b0);
    repeat (8) @(posedge clk_i);
    rdc("falling flags", `TCC_OFS_STATUS, 32'h0000_0004);
    wrr(`TCC_OFS_STATUS, 32'h0000_0004);
    wrr(`TCC_OFS_CTRL, 32'h0000_0000);
    rdr(`TCC_OFS_COUNT);
    a = q;
    pins.set_pin(0, 1'b1);
    repeat (8) @(posedge clk_i);
    wrr(`TCC_OFS_CTRL, 32'h0000_0020);
    rd16(0);
    chk_rng("running capture", a + 3, a + 6, 32'(v));
  endtask

  task automatic t_ext();
    wrr(`TCC_OFS_CTRL, 32'h0000_0037);
    wrr(`TCC_OFS_CTRL, 32'h0000_0007);
    pins.ext_pulses(5);
    repeat (10) @(posedge clk_i);
    wrr(`TCC_OFS_CTRL, 32'h0000_0027);
    rdc("external count", `TCC_OFS_COUNT, 32'h0000_0005);
  endtask

  task automatic close_out();
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  //////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    t_reset();
    t_count();
    t_ovf();
    t_cmp();
    t_cap();
    t_ext();
    close_out();
  end

  // run needs a few thousand cycles; limit is 30000
  initial begin
    #300_000;
    n_fail++;
    close_out();
  end
endmodule

`default_nettype wire
